// File: shared/irq_bank_pkg.sv
// Constants, register map and carrier types of the interrupt flag/enable bank.
// Assumes a single 8-bit register port on the same clock as the bank.
package irq_bank_pkg;

  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 8;
  localparam int NUM_CTL = 4;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTL0     = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTL1     = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CTL2     = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_CTL3     = 3'h4;

  // Implemented-bit masks and reset value
  localparam logic [DATA_W-1:0] REG_RESET       = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE       = 8'h00;
  localparam logic [DATA_W-1:0] EDGE_SEL_MASK   = 8'h0f;
  localparam logic [DATA_W-1:0] CTL0_MASK       = 8'h7f;
  localparam logic [DATA_W-1:0] CTL_FULL_MASK   = 8'hff;
  localparam logic [DATA_W-1:0] CTL3_NOCMP_MASK = 8'h33;
  localparam logic [DATA_W-1:0] CTL0_EN_MASK    = 8'h0e;
  localparam logic [DATA_W-1:0] CTL_EN_MASK     = 8'h0f;

  // Distance from an enable bit up to its request flag
  localparam int CTL0_FLAG_OFS = 3;
  localparam int CTL_FLAG_OFS  = 4;

  // Edge select fields
  localparam int PIN_A_SEL_LSB = 0;
  localparam int PIN_B_SEL_LSB = 2;
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Control 0 fields
  localparam int GLOBAL_EN_BIT  = 0;
  localparam int USB_FLAG_BIT   = 6;
  localparam int PIN_B_FLAG_BIT = 5;
  localparam int PIN_A_FLAG_BIT = 4;
  // Control 1 fields
  localparam int TBASE_B_FLAG_BIT  = 7;
  localparam int TBASE_A_FLAG_BIT  = 6;
  localparam int KEYSCAN_FLAG_BIT  = 5;
  localparam int PWM_FLAG_BIT      = 4;
  // Control 2 fields
  localparam int EEPROM_FLAG_BIT   = 7;
  localparam int TIMER_B_FLAG_BIT  = 6;
  localparam int TIMER_A_FLAG_BIT  = 5;
  localparam int LVD_FLAG_BIT      = 4;
  // Control 3 fields
  localparam int CMP_B_FLAG_BIT    = 7;
  localparam int CMP_A_FLAG_BIT    = 6;
  localparam int USB_SOF_FLAG_BIT  = 5;
  localparam int SPI_FLAG_BIT      = 4;

  // One-cycle event pulses from on-chip sources, same clock as the bank
  typedef struct packed {
    logic usb;
    logic tbaseB;
    logic tbaseA;
    logic keyscanFrame;
    logic pwmFrame;
    logic eeprom;
    logic timerB;
    logic timerA;
    logic lvd;
    logic cmpB;
    logic cmpA;
    logic usbSof;
    logic spi;
  } srcEvents_t;

  // Register port request group
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } regReq_t;

endpackage

// File: logic/mcu_interrupt_flag_enable_bank.sv
// Interrupt request flag and enable register bank of a small controller core.
// Assumes on-chip event pulses on ref_clk, asynchronous external pins, and a
// register master that issues one-cycle read or write strobes.
//
// Function
// - Accept two pins plus internal sources
// - Events set flags; per-source enable bits
// - Pending enabled request interrupts the core
// - Bits 3:2 select pin B edge
// - Bits 1:0 select pin A edge
// - Unimplemented bits read back zero
// - Global enable gates every interrupt
// - Control 0: USB and pin flags, enables
// - Control 1: time-base flags and enables
// - Control 1: key-scan flag bit5, enable bit1
// - Control 1: PWM-frame flag bit4, enable bit0
// - Disabled flag stays visible, no interrupt
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module mcu_interrupt_flag_enable_bank
  import irq_bank_pkg::*;
#(
  parameter bit HAS_COMPARATORS = 1'b1
)(
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire irq_bank_pkg::regReq_t   regReq,
  output logic [irq_bank_pkg::DATA_W-1:0] readData,
  input  wire irq_bank_pkg::srcEvents_t srcEvents,
  input  wire logic                    extIrqPinA,
  input  wire logic                    extIrqPinB,
  output logic                         irqReq
);
  import irq_bank_pkg::*;

  typedef struct packed {
    logic [1:0]                     pinASync;
    logic [1:0]                     pinBSync;
    logic                           pinAPrev;
    logic                           pinBPrev;
    logic [DATA_W-1:0]              edgeSel;
    logic [NUM_CTL-1:0][DATA_W-1:0] ctl;
    logic [DATA_W-1:0]              readData;
    logic                           irqReq;
  } state_t;

  state_t                         cur;
  state_t                         next_;
  logic [NUM_CTL-1:0][DATA_W-1:0] setBits;
  logic [NUM_CTL-1:0][DATA_W-1:0] pending;
  logic                           pinAHit;
  logic                           pinBHit;

  function automatic logic [ADDR_W-1:0] ctlAddr(input int k);
    unique case (k)
      0:       ctlAddr = ADDR_CTL0;
      1:       ctlAddr = ADDR_CTL1;
      2:       ctlAddr = ADDR_CTL2;
      default: ctlAddr = ADDR_CTL3;
    endcase
  endfunction

  // Implemented bits of each control register
  function automatic logic [DATA_W-1:0] ctlMask(input int k);
    if (k == 0)
    begin
      ctlMask = CTL0_MASK;
    end
    else if (k == NUM_CTL - 1 && !HAS_COMPARATORS)
    begin
      ctlMask = CTL3_NOCMP_MASK;
    end
    else
    begin
      ctlMask = CTL_FULL_MASK;
    end
  endfunction

  function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic now);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = prev & ~now;
    unique case (sel)
      EDGE_OFF:  edgeHit = 1'b0;
      EDGE_RISE: edgeHit = rise;
      EDGE_FALL: edgeHit = fall;
      EDGE_BOTH: edgeHit = rise | fall;
    endcase
  endfunction

  always_comb
  begin
    // Edges judged only on the second stage and its delayed copy
    pinAHit = edgeHit(cur.edgeSel[PIN_A_SEL_LSB +: 2], cur.pinAPrev, cur.pinASync[1]);
    pinBHit = edgeHit(cur.edgeSel[PIN_B_SEL_LSB +: 2], cur.pinBPrev, cur.pinBSync[1]);

    setBits = '0;
    setBits[0][USB_FLAG_BIT]     = srcEvents.usb;
    setBits[0][PIN_B_FLAG_BIT]   = pinBHit;
    setBits[0][PIN_A_FLAG_BIT]   = pinAHit;
    setBits[1][TBASE_B_FLAG_BIT] = srcEvents.tbaseB;
    setBits[1][TBASE_A_FLAG_BIT] = srcEvents.tbaseA;
    setBits[1][KEYSCAN_FLAG_BIT] = srcEvents.keyscanFrame;
    setBits[1][PWM_FLAG_BIT]     = srcEvents.pwmFrame;
    setBits[2][EEPROM_FLAG_BIT]  = srcEvents.eeprom;
    setBits[2][TIMER_B_FLAG_BIT] = srcEvents.timerB;
    setBits[2][TIMER_A_FLAG_BIT] = srcEvents.timerA;
    setBits[2][LVD_FLAG_BIT]     = srcEvents.lvd;
    setBits[3][CMP_B_FLAG_BIT]   = srcEvents.cmpB;
    setBits[3][CMP_A_FLAG_BIT]   = srcEvents.cmpA;
    setBits[3][USB_SOF_FLAG_BIT] = srcEvents.usbSof;
    setBits[3][SPI_FLAG_BIT]     = srcEvents.spi;

    next_ = cur;
    next_.pinASync = {cur.pinASync[0], extIrqPinA};
    next_.pinBSync = {cur.pinBSync[0], extIrqPinB};
    next_.pinAPrev = cur.pinASync[1];
    next_.pinBPrev = cur.pinBSync[1];

    if (regReq.wr && regReq.addr == ADDR_EDGE_SEL)
    begin
      next_.edgeSel = regReq.wdata & EDGE_SEL_MASK;
    end

    for (int k = 0; k < NUM_CTL; k++)
    begin
      if (regReq.wr && regReq.addr == ctlAddr(k))
      begin
        next_.ctl[k] = regReq.wdata & ctlMask(k);
      end
      // Hardware set is applied after the write so an event is never lost
      next_.ctl[k] = next_.ctl[k] | (setBits[k] & ctlMask(k));
    end

    // Flag shifted down onto its enable; disabled flags stay visible
    for (int k = 0; k < NUM_CTL; k++)
    begin
      if (k == 0)
      begin
        pending[k] = (cur.ctl[k] >> CTL0_FLAG_OFS) & cur.ctl[k] & CTL0_EN_MASK;
      end
      else
      begin
        pending[k] = (cur.ctl[k] >> CTL_FLAG_OFS) & cur.ctl[k] & CTL_EN_MASK;
      end
    end
    next_.irqReq = cur.ctl[0][GLOBAL_EN_BIT] & (|pending);

    next_.readData = READ_IDLE;
    if (regReq.rd)
    begin
      if (regReq.addr == ADDR_EDGE_SEL)
      begin
        next_.readData = cur.edgeSel & EDGE_SEL_MASK;
      end
      for (int k = 0; k < NUM_CTL; k++)
      begin
        if (regReq.addr == ctlAddr(k))
        begin
          next_.readData = cur.ctl[k] & ctlMask(k);
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cur          <= '0;
      cur.edgeSel  <= REG_RESET;
      cur.ctl      <= {NUM_CTL{REG_RESET}};
      cur.readData <= READ_IDLE;
    end
    else
    begin
      cur <= next_;
    end
  end

  assign readData = cur.readData;
  assign irqReq   = cur.irqReq;

endmodule

`default_nettype wire

// File: dv/pin_src_model.sv
// Far-side model of the two external request pins.
// Pins move 1 ns after an edge, as an unrelated driver would.
`timescale 1ns/1ps
`default_nettype none
module pin_src_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] pinLevel,
  output logic            extIrqPinA,
  output logic            extIrqPinB
);
  initial {extIrqPinB, extIrqPinA} = 2'b00;
  always @(posedge ref_clk)
    {extIrqPinB, extIrqPinA} <= #1 pinLevel;
endmodule
`default_nettype wire

// File: dv/irq_bank_asserts.sv
// Checker for the interrupt flag/enable bank.
// Sees only the top ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module irq_bank_checker (
  input wire logic                             ref_clk,
  input wire logic                             reset,
  input wire irq_bank_pkg::regReq_t            regReq,
  input wire logic [irq_bank_pkg::DATA_W-1:0]  readData,
  input wire irq_bank_pkg::srcEvents_t         srcEvents,
  input wire logic                             irqReq
);
  import irq_bank_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Shadow of control 0 enables
  logic [3:0] en;
  always_ff @(posedge ref_clk)
    if (reset)
      en <= 4'h0;
    else if (regReq.wr && regReq.addr == ADDR_CTL0)
      en <= regReq.wdata[3:0];
  property evFlag(ev, a, b);
    ev ##1 (regReq.rd && regReq.addr == a) |-> ##1 readData[b];
  endproperty
  usb_flag_a: assert property (evFlag(srcEvents.usb, ADDR_CTL0, 6)) else $error("usb flag");
  tbase_flag_a: assert property (evFlag(srcEvents.tbaseB, ADDR_CTL1, 7)) else $error("tbase flag");
  keyscan_flag_a: assert property (evFlag(srcEvents.keyscanFrame, ADDR_CTL1, 5)) else $error("ks flag");
  pwm_flag_a: assert property (evFlag(srcEvents.pwmFrame, ADDR_CTL1, 4)) else $error("pwm flag");
  eeprom_flag_a: assert property (evFlag(srcEvents.eeprom, ADDR_CTL2, 7)) else $error("ee flag");
  ctl0_top_a: assert property ($past(regReq.rd) && $past(regReq.addr) == ADDR_CTL0 |-> !readData[7])
    else $error("bit 7 set");
  global_off_a: assert property (!$past(en[0]) |-> !irqReq) else $error("irq without global");
  usb_irq_a: assert property (srcEvents.usb ##1 (en[3] && en[0]) |-> ##1 irqReq) else $error("no irq");
  cover property (srcEvents.usb ##2 irqReq);
  cover property (regReq.rd && regReq.addr == ADDR_EDGE_SEL);
  cover property ($fell(irqReq));
endmodule
bind mcu_interrupt_flag_enable_bank irq_bank_checker irq_bank_checker_i (.ref_clk(ref_clk), .reset(reset),
  .regReq(regReq), .readData(readData), .srcEvents(srcEvents), .irqReq(irqReq));
`default_nettype wire

// File: dv/mcu_interrupt_flag_enable_bank_bench.sv
// Self-checking bench for the interrupt flag/enable bank.
// Inputs move by NBA at the rising edge; pins come from the model.
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_flag_enable_bank_bench;
  import irq_bank_pkg::*;
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  regReq_t           rq = '0;
  srcEvents_t        ev = '0;
  logic [1:0]        pinLevel = 2'b00;
  logic [7:0]        readData;
  logic              pinA;
  logic              pinB;
  logic              irqReq;
  logic [7:0]        readData2;
  logic              irqReq2;
  int                failures = 0;
  int                totalChecks = 0;
  // Per source: register index high nibble, flag bit low nibble
  logic [7:0]        tbl [13] = '{8'h16, 8'h27, 8'h26, 8'h25, 8'h24, 8'h37, 8'h36, 8'h35, 8'h34,
                                  8'h47, 8'h46, 8'h45, 8'h44};
  mcu_interrupt_flag_enable_bank mcu_interrupt_flag_enable_bank_i (.ref_clk(ref_clk), .reset(reset),
    .regReq(rq), .readData(readData), .srcEvents(ev), .extIrqPinA(pinA), .extIrqPinB(pinB), .irqReq(irqReq));
  // Second copy without comparators, sharing every input with the first
  mcu_interrupt_flag_enable_bank #(.HAS_COMPARATORS(1'b0)) mcu_interrupt_flag_enable_bank_nocmp_i (
    .ref_clk(ref_clk), .reset(reset), .regReq(rq), .readData(readData2), .srcEvents(ev),
    .extIrqPinA(pinA), .extIrqPinB(pinB), .irqReq(irqReq2));
  pin_src_model pin_src_model_i (.ref_clk(ref_clk), .pinLevel(pinLevel), .extIrqPinA(pinA), .extIrqPinB(pinB));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    totalChecks++;
    if (s !== e)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    rq.wr <= 1'b0;
  endtask
  // Also ends any event pulse raised just before
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    ev <= '0;
    @(posedge ref_clk);
    rq.rd <= 1'b0;
    #1 chk(readData, e);
  endtask
  task automatic t_regs;
    logic [7:0] m [6] = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00};
    for (int a = 0; a < 6; a++)
      rd(a[2:0], 8'h00);
    for (int a = 0; a < 6; a++)
      wr(a[2:0], 8'hff);
    for (int a = 0; a < 6; a++)
      rd(a[2:0], m[a]);
    chk({7'h0, irqReq}, 8'h01);
    for (int a = 0; a < 6; a++)
      wr(a[2:0], 8'h00);
    rd(ADDR_CTL0, 8'h00);
  endtask
  // Every on-chip source with enables off but global on
  task automatic t_events;
    logic [2:0] a;
    wr(ADDR_CTL0, 8'h01);
    for (int j = 0; j < 13; j++)
    begin
      a = tbl[j][6:4];
      @(posedge ref_clk);
      ev <= 13'h1000 >> j;
      rd(a, (8'h01 << tbl[j][2:0]) | {7'h0, a == 3'h1});
      chk({7'h0, irqReq}, 8'h00);
      wr(a, {7'h0, a == 3'h1});
    end
    wr(ADDR_CTL0, 8'h00);
  endtask
  task automatic t_pins;
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 4; m++)
      begin
        wr(ADDR_EDGE_SEL, 8'(m << (2 * p)));
        for (int lv = 1; lv >= 0; lv--)
        begin
          pinLevel[p] <= lv[0];
          repeat (8) @(posedge ref_clk);
          rd(ADDR_CTL0, 8'(((lv != 0 ? m : m >> 1) & 1) << (4 + p)));
          wr(ADDR_CTL0, 8'h00);
        end
      end
  endtask
  task automatic t_irq;
    wr(ADDR_CTL0, 8'h09);
    @(posedge ref_clk);
    ev.usb <= 1'b1;
    rd(ADDR_CTL0, 8'h49);
    chk({7'h0, irqReq}, 8'h01);
    wr(ADDR_CTL0, 8'h48);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h0, irqReq}, 8'h00);
    rd(ADDR_CTL0, 8'h48);
    wr(ADDR_CTL0, 8'h00);
  endtask
  // Comparator bits only exist in the full variant
  task automatic t_nocmp;
    wr(ADDR_CTL0, 8'h01);
    wr(ADDR_CTL3, 8'hcc);
    rd(ADDR_CTL3, 8'hcc);
    chk(readData2, 8'hcc & CTL3_NOCMP_MASK);
    chk({7'h0, irqReq}, 8'h01);
    chk({7'h0, irqReq2}, 8'h00);
    wr(ADDR_CTL3, 8'h00);
    wr(ADDR_CTL0, 8'h00);
  endtask
  task automatic end_of_test;
    $display("checks=%0d failures=%0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_events();
    t_pins();
    t_irq();
    t_nocmp();
    end_of_test();
  end
  // Hang guard
  initial
  begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
